// ### hdl/sbf_params.svh
`ifndef SBF_PARAMS_SVH
`define SBF_PARAMS_SVH
// Byte addresses of the register words.
`define SBF_ADDR_DATA 5'h00
`define SBF_ADDR_STATUS 5'h04
`define SBF_ADDR_IRQ_STATUS 5'h08
`define SBF_ADDR_IRQ_CLEAR 5'h0c
`define SBF_ADDR_IRQ_ENABLE 5'h10
// Status and control field positions.
`define SBF_BIT_RX_FULL 0
`define SBF_BIT_TX_FULL 1
`define SBF_BIT_OVERFLOW 6
`define SBF_BIT_IDLE_STOP 13
`define SBF_BIT_PORT_ENABLE 15
// Interrupt event bit positions.
`define SBF_IRQ_RX_DONE 0
`define SBF_IRQ_TX_START 1
`define SBF_IRQ_OVERFLOW 2
`define SBF_IRQ_WIDTH 3
`define SBF_RESET_DATA 16'h0000
`endif

// ### hdl/sbf_pkg.sv
package sbf_pkg;
    typedef struct packed {
        logic port_enable;
        logic idle_stop_select;
        logic receive_overflow_flag;
        logic tx_buffer_full_flag;
        logic rx_buffer_full_flag;
    } sbf_status_t;
    typedef struct packed {
        logic [4:0] adr;
        logic we;
        logic [31:0] dat;
        logic [3:0] sel;
    } sbf_bus_req_t;
endpackage

// ### hdl/sbf_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbf_params.svh"
module sbf_status_flags
    import sbf_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Classic Wishbone slave.
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [4:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Shift register side.
    input wire logic chip_idle_in,
    input wire logic shift_ready_in,
    input wire logic shift_done_in,
    input wire logic [DATA_W-1:0] shift_rx_data_in,
    output logic shift_load_out,
    output logic [DATA_W-1:0] shift_tx_data_out,
    output logic module_run_out,
    // Interrupt.
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    sbf_bus_req_t req;
    logic access;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    // Holding buffers on either side of the shift register.
    logic [DATA_W-1:0] txb_q;
    logic [DATA_W-1:0] txb_d;
    logic [DATA_W-1:0] rxb_q;
    logic [DATA_W-1:0] rxb_d;
    // Status flags.
    logic tx_full_q;
    logic tx_full_d;
    logic rx_full_q;
    logic rx_full_d;
    logic ovf_q;
    logic ovf_d;
    // Control bits.
    logic idle_stop_q;
    logic idle_stop_d;
    logic enable_q;
    logic enable_d;
    // Interrupt status, enable and the events of this cycle.
    logic [`SBF_IRQ_WIDTH-1:0] irq_st_q;
    logic [`SBF_IRQ_WIDTH-1:0] irq_st_d;
    logic [`SBF_IRQ_WIDTH-1:0] irq_en_q;
    logic [`SBF_IRQ_WIDTH-1:0] irq_en_d;
    logic [`SBF_IRQ_WIDTH-1:0] irq_evt;
    // Qualified events and register decodes.
    logic running;
    logic load_ev;
    logic rx_ev;
    logic rx_lost;
    logic wr_data;
    logic rd_data;
    logic wr_ctl;
    logic wr_irq_clr;
    logic wr_irq_en;
    logic ovf_clr;
    sbf_status_t stat;

    assign req = '{adr: wb_adr_in, we: wb_we_in, dat: wb_dat_in, sel: wb_sel_in};
    // Ack is taken one cycle after the request and dropped the next, so every access is one-shot.
    assign access = wb_cyc_in && wb_stb_in && !ack_q;
    assign running = enable_q && !(idle_stop_q && chip_idle_in);
    assign wr_data = access && req.we && req.adr == `SBF_ADDR_DATA && req.sel[0];
    assign rd_data = access && !req.we && req.adr == `SBF_ADDR_DATA;
    assign wr_ctl = access && req.we && req.adr == `SBF_ADDR_STATUS;
    // Overflow is cleared by writing zero to its bit; a writer can only clear it.
    assign ovf_clr = wr_ctl && req.sel[0] && !req.dat[`SBF_BIT_OVERFLOW];
    assign load_ev = running && tx_full_q && shift_ready_in;
    assign rx_ev = running && shift_done_in;
    // A word finishing while the previous one is unread is lost; a read in the same cycle frees the buffer.
    assign rx_lost = rx_ev && rx_full_q && !rd_data;
    assign wr_irq_clr = access && req.we && req.adr == `SBF_ADDR_IRQ_CLEAR && req.sel[0];
    assign wr_irq_en = access && req.we && req.adr == `SBF_ADDR_IRQ_ENABLE && req.sel[0];
    assign stat = '{port_enable: enable_q, idle_stop_select: idle_stop_q,
                    receive_overflow_flag: ovf_q, tx_buffer_full_flag: tx_full_q,
                    rx_buffer_full_flag: rx_full_q};

    ////////////////////////////////////////////////////////////////////////////
    // Transmit side. A write in the same cycle as a move refills the buffer, so the flag stays set.
    always_comb
    begin
        txb_d = txb_q;
        tx_full_d = tx_full_q;
        if (load_ev)
        begin
            tx_full_d = 1'b0;
        end
        if (wr_data)
        begin
            txb_d = req.dat[DATA_W-1:0];
            tx_full_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            txb_q <= `SBF_RESET_DATA;
            tx_full_q <= 1'b0;
        end
        else
        begin
            txb_q <= txb_d;
            tx_full_q <= tx_full_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive side. On overflow the unread word is kept and the new one dropped.
    always_comb
    begin
        rxb_d = rxb_q;
        rx_full_d = rx_full_q;
        ovf_d = ovf_q;
        if (rd_data)
        begin
            rx_full_d = 1'b0;
        end
        // A lost word sets the flag even when software clears it in the same cycle.
        if (ovf_clr)
        begin
            ovf_d = 1'b0;
        end
        if (rx_lost)
        begin
            ovf_d = 1'b1;
        end
        else if (rx_ev)
        begin
            rxb_d = shift_rx_data_in;
            rx_full_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rxb_q <= `SBF_RESET_DATA;
            rx_full_q <= 1'b0;
            ovf_q <= 1'b0;
        end
        else
        begin
            rxb_q <= rxb_d;
            rx_full_q <= rx_full_d;
            ovf_q <= ovf_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control bits sit in the upper byte lane; of the flags below them only overflow is writable, and only to clear it.
    always_comb
    begin
        idle_stop_d = idle_stop_q;
        enable_d = enable_q;
        if (wr_ctl && req.sel[1])
        begin
            idle_stop_d = req.dat[`SBF_BIT_IDLE_STOP];
            enable_d = req.dat[`SBF_BIT_PORT_ENABLE];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            idle_stop_q <= 1'b0;
            enable_q <= 1'b0;
        end
        else
        begin
            idle_stop_q <= idle_stop_d;
            enable_q <= enable_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        irq_evt = '0;
        irq_evt[`SBF_IRQ_RX_DONE] = rx_ev && !rx_lost;
        irq_evt[`SBF_IRQ_TX_START] = load_ev;
        irq_evt[`SBF_IRQ_OVERFLOW] = rx_lost;
        // New events win over a clear in the same cycle.
        irq_st_d = irq_st_q;
        if (wr_irq_clr)
        begin
            irq_st_d = irq_st_q & ~req.dat[`SBF_IRQ_WIDTH-1:0];
        end
        irq_st_d = irq_st_d | irq_evt;
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_st_q <= '0;
        end
        else
        begin
            irq_st_q <= irq_st_d;
        end
    end

    // The enable word only gates the pin; status bits keep collecting while disabled.
    always_comb
    begin
        irq_en_d = irq_en_q;
        if (wr_irq_en)
        begin
            irq_en_d = req.dat[`SBF_IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_en_q <= '0;
        end
        else
        begin
            irq_en_q <= irq_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        // Read data is registered with the ack, so the master finds both in one cycle.
        // Writes and unmapped reads return zero on the data lines.
        ack_d = access;
        rdata_d = '0;
        if (access && !req.we)
        begin
            unique case (req.adr)
                `SBF_ADDR_DATA: rdata_d[DATA_W-1:0] = rxb_q;
                `SBF_ADDR_STATUS:
                begin
                    rdata_d[`SBF_BIT_RX_FULL] = stat.rx_buffer_full_flag;
                    rdata_d[`SBF_BIT_TX_FULL] = stat.tx_buffer_full_flag;
                    rdata_d[`SBF_BIT_OVERFLOW] = stat.receive_overflow_flag;
                    rdata_d[`SBF_BIT_IDLE_STOP] = stat.idle_stop_select;
                    rdata_d[`SBF_BIT_PORT_ENABLE] = stat.port_enable;
                end
                `SBF_ADDR_IRQ_STATUS: rdata_d[`SBF_IRQ_WIDTH-1:0] = irq_st_q;
                `SBF_ADDR_IRQ_ENABLE: rdata_d[`SBF_IRQ_WIDTH-1:0] = irq_en_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The move strobe is combinational so the peer and the transmit flag act in the same cycle.
    // A user must hold shift_ready_in low while the shift register is busy, or a word is overwritten.
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdata_q;
    assign shift_load_out = load_ev;
    assign shift_tx_data_out = txb_q;
    assign module_run_out = running;
    assign irq_out = |(irq_st_q & irq_en_q);

endmodule // sbf_status_flags
`default_nettype wire

// ### test/sbf_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sbf_chk #(parameter int DATA_W = 16) (
    // Bus.
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic wb_ack_out,
    input wire logic [4:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    // Shift side.
    input wire logic chip_idle_in,
    input wire logic shift_ready_in,
    input wire logic shift_load_out,
    input wire logic [DATA_W-1:0] shift_tx_data_out,
    input wire logic module_run_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    wire tk = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire tw = tk && wb_we_in;
    wire wr = tw && wb_adr_in == 5'h00 && wb_sel_in[0];
    sequence s_pulse; wb_ack_out ##1 !wb_ack_out; endsequence
    property p_ack; tk |=> s_pulse; endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_tx; wr && module_run_out |=> shift_tx_data_out == $past(wb_dat_in[DATA_W-1:0]); endproperty
    a_tx: assert property (p_tx) else $error("tx buffer not loaded");
    property p_go; wr && module_run_out && shift_ready_in ##1 shift_ready_in && module_run_out |-> shift_load_out; endproperty
    a_go: assert property (p_go) else $error("written word not moved");
    property p_ok; shift_load_out |-> shift_ready_in && module_run_out; endproperty
    a_ok: assert property (p_ok) else $error("move while not allowed");
    property p_one; shift_load_out && !wr |=> !shift_load_out; endproperty
    a_one: assert property (p_one) else $error("word moved twice");
    property p_run; $changed(module_run_out) |-> $changed(chip_idle_in) || $past(tw); endproperty
    a_run: assert property (p_run) else $error("run changed without cause");
endmodule // sbf_chk
bind sbf_status_flags sbf_chk #(.DATA_W(DATA_W)) chk_i (.*);
`default_nettype wire

// ### test/sbf_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sbf_peer (
    // Link.
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic go_in,
    input wire logic [15:0] word_in,
    output logic ready_out,
    output logic done_out,
    output logic [15:0] data_out
);
    logic [2:0] busy_q;
    // Data toggles outside done so a stale word never looks fresh.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            busy_q <= 3'h0;
            done_out <= 1'b0;
            data_out <= 16'h0;
        end
        else
        begin
            busy_q <= load_in ? 3'h7 : busy_q - {2'h0, busy_q != 3'h0};
            done_out <= go_in;
            data_out <= go_in ? word_in : ~data_out;
        end
    end
    assign ready_out = busy_q == 3'h0;
endmodule // sbf_peer
`default_nettype wire

// ### test/sbf_status_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
module sbf_status_flags_test;
    logic core_clk_in = 1'b0, rst_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0, chip_idle_in = 1'b0, go = 1'b0;
    logic [4:0] wb_adr_in = 5'h00;
    logic [3:0] wb_sel_in = 4'hf;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
    logic [15:0] word = 16'h0, shift_rx_data_in, shift_tx_data_out;
    logic wb_ack_out, shift_ready_in, shift_done_in, shift_load_out, module_run_out, irq_out;
    int fail_count = 0;
    int n_compared = 0;
    always #2.5 core_clk_in = ~core_clk_in;
    sbf_status_flags DUT (.*);
    sbf_peer peer (.clk_in(core_clk_in), .rst_in(rst_in), .load_in(shift_load_out), .go_in(go), .word_in(word),
        .ready_out(shift_ready_in), .done_out(shift_done_in), .data_out(shift_rx_data_in));
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, logic [4:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= a;
        wb_dat_in <= d;
        do
            @(posedge core_clk_in);
        while (wb_ack_out !== 1'b1 && ++n < 50);
        if (n >= 50)
            fail_count++;
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask
    task automatic rdc(input string nm, logic [4:0] a, logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic rx(input logic [15:0] w);
        @(posedge core_clk_in);
        go <= 1'b1;
        word <= w;
        @(posedge core_clk_in);
        go <= 1'b0;
        repeat (2) @(posedge core_clk_in);
    endtask
    task automatic idle_run(input logic i, e);
        chip_idle_in <= i;
        @(posedge core_clk_in);
        chk("run", {31'h0, e}, {31'h0, module_run_out});
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rdc("status", 4'h4, 32'h0);
        acc(1'b1, 4'h4, 32'h8000);
        idle_run(1'b1, 1'b1);
        $display("enable test done");
        acc(1'b1, 4'h0, 32'h1234);
        acc(1'b1, 4'h0, 32'h5678);
        rdc("status", 4'h4, 32'h8002);
        repeat (10) @(posedge core_clk_in);
        rdc("status", 4'h4, 32'h8000);
        chk("tx", 32'h5678, {16'h0, shift_tx_data_out});
        $display("transmit test done");
        rx(16'hbeef);
        rdc("status", 4'h4, 32'h8001);
        rdc("data", 4'h0, 32'hbeef);
        rdc("status", 4'h4, 32'h8000);
        rx(16'h1111);
        rx(16'h2222);
        rdc("status", 4'h4, 32'h8041);
        rdc("data", 4'h0, 32'h1111);
        acc(1'b1, 4'h4, 32'h8000);
        rdc("status", 4'h4, 32'h8000);
        $display("receive test done");
        rdc("irq", 4'h8, 32'h7);
        acc(1'b1, 4'hc, 32'h7);
        rdc("irq", 4'h8, 32'h0);
        rdc("unmapped", 4'h2, 32'h0);
        chk("irq pin", 32'h0, {31'h0, irq_out});
        acc(1'b1, 5'h10, 32'h1);
        rdc("irq enable", 5'h10, 32'h1);
        rx(16'h3333);
        chk("irq pin", 32'h1, {31'h0, irq_out});
        rdc("data", 5'h00, 32'h3333);
        acc(1'b1, 5'h0c, 32'h7);
        chk("irq pin", 32'h0, {31'h0, irq_out});
        $display("interrupt test done");
        acc(1'b1, 4'h4, 32'ha000);
        rdc("status", 4'h4, 32'ha000);
        idle_run(1'b1, 1'b0);
        idle_run(1'b0, 1'b1);
        $display("idle test done");
        summarize();
    end
    initial
    begin
        #10000;
        fail_count++;
        summarize();
    end
endmodule // sbf_status_flags_test
`default_nettype wire
